//--- rtl/trim_defs.svh
// constants for the converter trim register bank
// assumes APB byte addressing, one 32-bit word per register index
`ifndef TRIM_DEFS_SVH
`define TRIM_DEFS_SVH

// printed register indices; byte address is four times the index
`define TRIM_IDX_OFS_IN_A   12'h34C
`define TRIM_IDX_OFS_IN_B   12'h34E
`define TRIM_IDX_GAIN_A0    12'h350
`define TRIM_IDX_GAIN_A1    12'h351
`define TRIM_ADDR_SHIFT     2

`define TRIM_NREGS          4
// the first two indices are the 16-bit offset registers
`define TRIM_NUM_OFS        2
`define TRIM_SEL_OFS_IN_A   4'h1
`define TRIM_SEL_OFS_IN_B   4'h2
`define TRIM_SEL_GAIN_A0    4'h4
`define TRIM_SEL_GAIN_A1    4'h8
`define TRIM_SEL_NONE       4'h0

// implemented bits per register, reserved bits included
`define TRIM_MASK_OFS       16'hFFFF
`define TRIM_MASK_GAIN      16'h00FF
`define TRIM_RESET_VAL      16'h0000

// field positions
`define TRIM_OFS_MSB        11
`define TRIM_GAIN_MSB       4

`define TRIM_ZERO_WORD      32'h0000_0000
`endif

//--- rtl/trim_pkg.sv
// types shared by the trim register bank
// assumes trim_defs.svh is on the include path
`include "trim_defs.svh"

package trim_pkg;

  typedef logic [15:0] trim_word_t;

  typedef struct packed {
    logic [11:0] paddr;
    logic        pwrite;
    logic [31:0] pwdata;
  } apb_req_s;

  typedef struct packed {
    logic [11:0] b_offset;
    logic        b_offset_on;
    logic [4:0]  a_bank0_gain;
    logic [4:0]  a_bank1_gain;
    logic        a_gain_on;
  } trim_out_s;

  typedef enum logic [2:0] {
    ST_FUSE = 3'b001,
    ST_IDLE = 3'b010,
    ST_RESP = 3'b100
  } bank_state_e;

endpackage

//--- rtl/adc_offset_gain_trim_regs.sv
// trim register bank: B-core offsets per input, A-core dual mode fine gains
// assumes an APB master on i_clk, and a fuse reader and mode controls on i_clk
//
// Operation
// - B core sampling input A gets 12-bit offset, bits 11:0, when foreground cal on.
// - B core sampling input B gets its own 12-bit offset, any channel mode.
// - both B-core offset defaults load from fuse memory, not a constant.
// - A core bank 0 uses 5-bit fine gain, bits 4:0, in dual mode.
// - A core bank 1 uses its own 5-bit fine gain in dual mode.
`timescale 1ns/1ps
`include "trim_defs.svh"

module adc_offset_gain_trim_regs
  import trim_pkg::*;
(
  input  wire logic        i_clk,
  input  wire logic        i_arst_n,
  input  wire logic        i_ce,
  // apb slave
  input  wire logic        i_psel,
  input  wire logic        i_penable,
  input  wire apb_req_s    i_req,
  output logic             o_pready,
  output logic [31:0]      o_prdata,
  output logic             o_pslverr,
  // fuse defaults
  input  wire logic        i_fuse_valid,
  input  wire trim_word_t  i_fuse_ofs_in_a,
  input  wire trim_word_t  i_fuse_ofs_in_b,
  input  wire trim_word_t  i_fuse_gain_a0,
  input  wire trim_word_t  i_fuse_gain_a1,
  // operating mode
  input  wire logic        i_fg_cal_en,
  input  wire logic        i_dual_mode,
  input  wire logic        i_b_samples_input_b,
  output trim_out_s        o_trim,
  output logic             o_fuse_loaded
);

  bank_state_e        state_r;
  bank_state_e        state_nxt;
  trim_word_t         regs_r [`TRIM_NREGS];
  trim_word_t         fuse_w [`TRIM_NREGS];
  logic [3:0]         sel;
  logic               access;
  logic               wr_commit;
  logic               load_fuse;
  logic [31:0]        rd_nxt;
  logic [11:0]        b_offset_r;
  logic               b_offset_on_r;
  logic [4:0]         a_bank0_gain_r;
  logic [4:0]         a_bank1_gain_r;
  logic               a_gain_on_r;

  // one-hot register select from a byte address; also used for read mux
  function automatic logic [3:0] decode(input logic [11:0] addr);
    logic [11:0] idx;
    idx = addr >> `TRIM_ADDR_SHIFT;
    if (addr[`TRIM_ADDR_SHIFT-1:0] != 2'b00) begin
      decode = `TRIM_SEL_NONE;
    end else begin
      case (idx)
        `TRIM_IDX_OFS_IN_A: decode = `TRIM_SEL_OFS_IN_A;
        `TRIM_IDX_OFS_IN_B: decode = `TRIM_SEL_OFS_IN_B;
        `TRIM_IDX_GAIN_A0:  decode = `TRIM_SEL_GAIN_A0;
        `TRIM_IDX_GAIN_A1:  decode = `TRIM_SEL_GAIN_A1;
        default:            decode = `TRIM_SEL_NONE;
      endcase
    end
  endfunction

  function automatic trim_word_t reg_mask(input int unsigned n);
    if (n < `TRIM_NUM_OFS) begin
      reg_mask = `TRIM_MASK_OFS;
    end else begin
      reg_mask = `TRIM_MASK_GAIN;
    end
  endfunction

  assign fuse_w[0] = i_fuse_ofs_in_a;
  assign fuse_w[1] = i_fuse_ofs_in_b;
  assign fuse_w[2] = i_fuse_gain_a0;
  assign fuse_w[3] = i_fuse_gain_a1;

  assign sel       = decode(i_req.paddr);
  assign access    = i_psel && i_penable;
  assign load_fuse = (state_r == ST_FUSE) && i_fuse_valid;
  // a write lands only at the edge where pready is seen high
  assign wr_commit = (state_r == ST_RESP) && access && i_req.pwrite;

  // ---------------------------------------------------------------
  // sequencing: the bus is stalled until fuse defaults have landed,
  // so software never reads a trim value that is still zero
  // ---------------------------------------------------------------
  always_comb begin
    state_nxt = state_r;
    case (state_r)
      ST_FUSE: begin
        if (i_fuse_valid) begin
          state_nxt = ST_IDLE;
        end
      end
      ST_IDLE: begin
        if (access) begin
          state_nxt = ST_RESP;
        end
      end
      ST_RESP: begin
        state_nxt = ST_IDLE;
      end
      default: begin
        state_nxt = ST_FUSE;
      end
    endcase
  end

  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      state_r <= ST_FUSE;
    end else if (i_ce) begin
      state_r <= state_nxt;
    end
  end

  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      o_fuse_loaded <= 1'b0;
    end else if (i_ce && load_fuse) begin
      o_fuse_loaded <= 1'b1;
    end
  end

  // ---------------------------------------------------------------
  // storage; reserved bits inside the register mask are read/write like the data bits, those above it read zero
  // ---------------------------------------------------------------
  genvar g;
  generate
    for (g = 0; g < `TRIM_NREGS; g++) begin : g_reg
      always_ff @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
          regs_r[g] <= `TRIM_RESET_VAL;
        end else if (i_ce) begin
          if (load_fuse) begin
            regs_r[g] <= fuse_w[g] & reg_mask(g);
          end else if (wr_commit && sel[g]) begin
            regs_r[g] <= i_req.pwdata[15:0] & reg_mask(g);
          end
        end
      end
    end
  endgenerate

  // ---------------------------------------------------------------
  // apb answer: one wait state, read data captured with pready
  // ---------------------------------------------------------------
  always_comb begin
    rd_nxt = `TRIM_ZERO_WORD;
    for (int n = 0; n < `TRIM_NREGS; n++) begin
      if (sel[n]) begin
        rd_nxt = {16'h0000, regs_r[n]};
      end
    end
  end

  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      o_pready <= 1'b0;
    end else if (i_ce) begin
      o_pready <= (state_r == ST_IDLE) && access;
    end
  end

  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      o_prdata  <= `TRIM_ZERO_WORD;
      o_pslverr <= 1'b0;
    end else if (i_ce) begin
      if ((state_r == ST_IDLE) && access) begin
        o_prdata  <= i_req.pwrite ? `TRIM_ZERO_WORD : rd_nxt;
        o_pslverr <= (sel == `TRIM_SEL_NONE);
      end else begin
        o_prdata  <= `TRIM_ZERO_WORD;
        o_pslverr <= 1'b0;
      end
    end
  end

  // ---------------------------------------------------------------
  // corrections to the cores; zero while not applicable so a stale
  // trim never leaks into uncalibrated sampling
  // ---------------------------------------------------------------
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      b_offset_r    <= 12'h000;
      b_offset_on_r <= 1'b0;
    end else if (i_ce) begin
      b_offset_on_r <= i_fg_cal_en;
      if (!i_fg_cal_en) begin
        b_offset_r <= 12'h000;
      end else if (i_b_samples_input_b) begin
        b_offset_r <= regs_r[1][`TRIM_OFS_MSB:0];
      end else begin
        b_offset_r <= regs_r[0][`TRIM_OFS_MSB:0];
      end
    end
  end

  // gains follow the channel mode; single channel gains live elsewhere
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      a_bank0_gain_r <= 5'h00;
      a_bank1_gain_r <= 5'h00;
      a_gain_on_r    <= 1'b0;
    end else if (i_ce) begin
      a_gain_on_r <= i_fg_cal_en && i_dual_mode;
      if (i_fg_cal_en && i_dual_mode) begin
        a_bank0_gain_r <= regs_r[2][`TRIM_GAIN_MSB:0];
        a_bank1_gain_r <= regs_r[3][`TRIM_GAIN_MSB:0];
      end else begin
        a_bank0_gain_r <= 5'h00;
        a_bank1_gain_r <= 5'h00;
      end
    end
  end

  // fields live in separate flops so each process owns its own variables;
  // the struct is only wiring, so the outputs still come from flops
  assign o_trim = '{b_offset:     b_offset_r,
                    b_offset_on:  b_offset_on_r,
                    a_bank0_gain: a_bank0_gain_r,
                    a_bank1_gain: a_bank1_gain_r,
                    a_gain_on:    a_gain_on_r};

endmodule // adc_offset_gain_trim_regs

//--- tb/trim_regs_sva.sv
// checker for the trim bank ports
// assumes bind from the bench top, ports matched by name
`timescale 1ns/1ps
module trim_regs_sva
  import trim_pkg::*;
(
  input wire logic        i_clk,
  input wire logic        i_arst_n,
  input wire logic        i_ce,
  input wire logic        i_psel,
  input wire logic        i_penable,
  input wire logic        o_pready,
  input wire logic [31:0] o_prdata,
  input wire logic        o_pslverr,
  input wire logic        i_fg_cal_en,
  input wire logic        i_dual_mode,
  input wire trim_out_s   o_trim,
  input wire logic        o_fuse_loaded
);
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_arst_n);
  sequence s_access;
    i_psel && i_penable && i_ce && o_fuse_loaded && !o_pready;
  endsequence
  sequence s_done;
    o_pready ##1 !o_pready;
  endsequence
  property p_answer; s_access |=> s_done; endproperty
  property p_stall; !o_fuse_loaded |-> !o_pready; endproperty
  property p_err; o_pslverr |-> o_pready && o_prdata == 32'h0000_0000; endproperty
  property p_idle; !o_pready |-> o_prdata == 32'h0000_0000; endproperty
  property p_ofs_off;
    i_arst_n && !i_fg_cal_en && i_ce |=> o_trim.b_offset == 12'h000 && !o_trim.b_offset_on;
  endproperty
  property p_ofs_on; i_arst_n && i_fg_cal_en && i_ce |=> o_trim.b_offset_on; endproperty
  property p_gain;
    i_arst_n && i_ce |=> o_trim.a_gain_on == $past(i_fg_cal_en && i_dual_mode);
  endproperty
  property p_freeze;
    i_arst_n && !i_ce |=> $stable(o_trim) && $stable(o_pready) && $stable(o_prdata);
  endproperty
  a_answer: assert property (p_answer) else $error("access not answered in one wait");
  a_stall: assert property (p_stall) else $error("answer before fuse load");
  a_err: assert property (p_err) else $error("error reply carries data");
  a_idle: assert property (p_idle) else $error("read data outside reply");
  a_ofs_off: assert property (p_ofs_off) else $error("offset applied without cal");
  a_ofs_on: assert property (p_ofs_on) else $error("offset not applied");
  a_gain: assert property (p_gain) else $error("gain enable wrong");
  a_freeze: assert property (p_freeze) else $error("outputs moved with enable low");
endmodule // trim_regs_sva

//--- tb/adc_offset_gain_trim_regs_tb.sv
// bench for the trim bank: apb access, fuse load, correction outputs
// assumes trim_pkg and the checker are compiled first
`timescale 1ns/1ps
module adc_offset_gain_trim_regs_tb
  import trim_pkg::*;
;
  logic        i_clk = 0, i_arst_n = 0, psel = 0, pen = 0, fv = 0, ce = 1;
  logic        cal = 0, dual = 0, selb = 0, o_pready, o_pslverr, o_fuse_loaded;
  logic [31:0] o_prdata;
  trim_out_s   o_trim;
  apb_req_s    req = '0;
  trim_word_t  fa = 16'hA5C3, fb = 16'h5A3C, f0 = 16'h00F7, f1 = 16'h1234;
  logic [11:0] ad [4] = '{12'hD30, 12'hD38, 12'hD40, 12'hD44};
  int          err_total = 0, check_count = 0;

  adc_offset_gain_trim_regs adc_offset_gain_trim_regs_i (.i_clk, .i_arst_n, .i_ce(ce),
    .i_psel(psel), .i_penable(pen), .i_req(req), .o_pready, .o_prdata, .o_pslverr,
    .i_fuse_valid(fv), .i_fuse_ofs_in_a(fa), .i_fuse_ofs_in_b(fb), .i_fuse_gain_a0(f0),
    .i_fuse_gain_a1(f1), .i_fg_cal_en(cal), .i_dual_mode(dual),
    .i_b_samples_input_b(selb), .o_trim, .o_fuse_loaded);

  task automatic chk(input logic [32:0] g, input logic [32:0] x);
    check_count++;
    if (g !== x) begin
      err_total++;
      $display("[FAIL] %0t got %h exp %h", $time, g, x);
    end
  endtask
  // request held until pready is sampled high
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
                     input logic [32:0] x);
    @(posedge i_clk);
    psel <= 1;
    req  <= '{a, w, d};
    @(posedge i_clk);
    pen <= 1;
    do @(posedge i_clk); while (o_pready !== 1'b1);
    chk({o_pslverr, o_prdata}, x);
    psel <= 0;
    pen  <= 0;
  endtask
  task automatic mode(input logic c, input logic d, input logic b, input logic [23:0] x);
    cal  <= c;
    dual <= d;
    selb <= b;
    repeat (3) @(posedge i_clk);
    chk(o_trim, x);
  endtask
  task automatic wrap_up;
    $display("checks %0d mismatches %0d", check_count, err_total);
    if (err_total == 0 && check_count > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  initial forever #5 i_clk = ~i_clk;
  initial begin
    repeat (5000) @(posedge i_clk);
    err_total++;
    wrap_up;
  end
  initial begin
    repeat (12) @(posedge i_clk);
    i_arst_n <= 1;
    repeat (2) @(posedge i_clk);
    chk(o_fuse_loaded, 0);
    fv <= 1;
    @(posedge i_clk);
    fv <= 0;
    @(posedge i_clk);
    chk(o_fuse_loaded, 1);
    apb(0, ad[0], 0, {17'h0, fa});
    apb(0, ad[1], 0, {17'h0, fb});
    apb(0, ad[2], 0, {25'h0, f0[7:0]});
    apb(0, ad[3], 0, {25'h0, f1[7:0]});
    $display("fuse test done");
    for (int i = 0; i < 4; i++) begin
      apb(1, ad[i], 32'hFFFF_FFFF, 33'h0);
      apb(0, ad[i], 0, (i < 2) ? 33'hFFFF : 33'hFF);
    end
    apb(1, 12'hD34, 32'h1, 33'h1_0000_0000);
    apb(0, 12'hD32, 0, 33'h1_0000_0000);
    $display("register test done");
    apb(1, ad[0], 32'h1123, 33'h0);
    apb(1, ad[1], 32'h2456, 33'h0);
    apb(1, ad[2], 32'hE9, 33'h0);
    apb(1, ad[3], 32'h2A, 33'h0);
    mode(1, 1, 0, {12'h123, 1'b1, 5'h09, 5'h0A, 1'b1});
    mode(1, 1, 1, {12'h456, 1'b1, 5'h09, 5'h0A, 1'b1});
    mode(1, 0, 1, {12'h456, 1'b1, 11'h0});
    mode(1, 0, 0, {12'h123, 1'b1, 11'h0});
    ce <= 0;
    mode(1, 1, 0, {12'h123, 1'b1, 11'h0});
    ce <= 1;
    mode(1, 1, 0, {12'h123, 1'b1, 5'h09, 5'h0A, 1'b1});
    mode(0, 1, 0, 24'h0);
    $display("output test done");
    fv <= 1;
    @(posedge i_clk);
    fv <= 0;
    apb(0, ad[0], 0, 33'h1123);
    i_arst_n <= 0;
    repeat (2) @(posedge i_clk);
    chk(o_fuse_loaded, 0);
    i_arst_n <= 1;
    @(posedge i_clk);
    fv <= 1;
    @(posedge i_clk);
    fv <= 0;
    apb(0, ad[0], 0, {17'h0, fa});
    apb(0, ad[3], 0, {25'h0, f1[7:0]});
    $display("reset test done");
    wrap_up;
  end
endmodule // adc_offset_gain_trim_regs_tb

bind adc_offset_gain_trim_regs trim_regs_sva trim_regs_sva_i (.*);
